// *** bench/pll_osc_status_ctrl_chk.sv ***
// Concurrent checks on the clock controller slice ports
`timescale 1ns/1ns
module pll_osc_status_chk (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic slow_xtal_ready,
	input wire logic main_xtal_ready,
	input wire logic pll_output_clock,
	input wire logic pll_locked_out,
	input wire logic irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic [5:0] hist;
	logic seen;
	logic arhs;
	assign arhs = s_axi_arvalid && s_axi_arready;
	// Ready history: a clear only sticks when no new rise is in flight
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			hist <= 6'h00;
			seen <= 1'b0;
		end else begin
			hist <= {hist[4:0], main_xtal_ready | slow_xtal_ready};
			seen <= seen | main_xtal_ready | slow_xtal_ready;
		end
	end
	AST_IRQ_NEEDS_READY: assert property (!seen |-> !irq)
		else $error("irq high without any ready rise");
	AST_IRQ_CLEAR: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready && s_axi_awaddr == 8'h08 && s_axi_wdata[1:0] == 2'b11 && hist == 6'h00 &&
		!main_xtal_ready && !slow_xtal_ready |-> ##[2:4] !irq)
		else $error("irq stays high after flag clear");
	AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##[1:3] s_axi_bvalid)
		else $error("write response missing");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
		$stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
		$stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address accepted while answer pending");
	AST_STATUS_RESV: assert property (arhs && s_axi_araddr == 8'h0c |=> s_axi_rvalid &&
		s_axi_rresp == 2'b00 && (s_axi_rdata & 32'hfffc79fc) == 32'h00000000)
		else $error("status read shows unused bits");
	AST_UNMAPPED: assert property (arhs && s_axi_araddr == 8'h40 |=> s_axi_rvalid &&
		s_axi_rresp == 2'b10 && s_axi_rdata == 32'h00000000)
		else $error("unmapped read not refused");
	AST_OUT_GATED: assert property (!pll_locked_out && $past(pll_locked_out) == 1'b0 |->
		!pll_output_clock)
		else $error("pll output runs while unlocked");
	COV_IRQ: cover property ($rose(irq));
	COV_LOCK: cover property ($rose(pll_locked_out));
	COV_SLVERR: cover property (arhs && s_axi_araddr == 8'h40);
endmodule
bind pll_osc_status_ctrl pll_osc_status_chk u_pll_osc_status_chk (.*);

// *** bench/ref_osc_model.sv ***
// Behavioural reference oscillators, ready levels and lock timer clock
`timescale 1ns/1ns
module ref_osc_model (
	input wire logic main_on,
	input wire logic slow_on,
	output logic low_speed_crystal_osc,
	output logic main_crystal_osc,
	output logic pll_ref_generic_channel,
	output logic pll_lock_timer_clock,
	output logic slow_xtal_ready,
	output logic main_xtal_ready,
	output logic brownout_ready,
	output logic brownout_detect
);
	initial begin
		low_speed_crystal_osc = 1'b0;
		main_crystal_osc = 1'b0;
		pll_ref_generic_channel = 1'b0;
		pll_lock_timer_clock = 1'b0;
		brownout_detect = 1'b0;
		// Ready levels start low so status never reads unknown
		slow_xtal_ready = 1'b0;
		main_xtal_ready = 1'b0;
		brownout_ready = 1'b0;
	end
	// Sources run before any PLL use, rates inside the PLL range
	always #32 low_speed_crystal_osc = ~low_speed_crystal_osc;
	always #12 main_crystal_osc = ~main_crystal_osc;
	always #20 pll_ref_generic_channel = ~pll_ref_generic_channel;
	// Far faster than 32 kHz so a time-out fits a short run
	always #100 pll_lock_timer_clock = ~pll_lock_timer_clock;
	// Ready follows start-up of each crystal
	always @(main_on) main_xtal_ready <= #100 main_on;
	always @(slow_on) slow_xtal_ready <= #100 slow_on;
	always @(main_on) brownout_ready <= #40 main_on;
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the clock controller slice
`timescale 1ns/1ns
module testbench;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, rdv;
	logic low_speed_crystal_osc, main_crystal_osc, pll_ref_generic_channel;
	logic pll_lock_timer_clock, slow_xtal_ready, main_xtal_ready;
	logic brownout_ready, brownout_detect, pll_reference_clock, pll_output_clock;
	logic pll_locked_out, irq;
	logic main_on = 1'b0;
	logic slow_on = 1'b0;
	logic [1:0] rr;
	logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
	int rst [7] = '{0, 0, 0, 0, 0, 32'h00010000, 32'h00000040};
	int n_fail = 0;
	int num_checks = 0;
	int seed = 64;
	int cyc = 0;
	int flags = 0;
	int i, j, c, d;
	pll_osc_status_ctrl u_pll_osc_status_ctrl (.*);
	ref_osc_model u_ref_osc_model (.*);
	always #2 sys_clk = ~sys_clk;
	task finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			finish_test;
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Address and data offered together, each dropped once taken
	task wr(input logic [7:0] a, input logic [31:0] v);
		logic ad;
		logic dd;
		ad = 1'b0;
		dd = 1'b0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			ad |= s_axi_awready === 1'b1;
			dd |= s_axi_wready === 1'b1;
			s_axi_awvalid <= !ad;
			s_axi_wvalid <= !dd;
		end while (!(ad && dd));
		s_axi_bready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a, rdv, rr);
		check(rdv & m, e);
	endtask
	task tog(input int w, output int n);
		logic p;
		logic v;
		n = 0;
		p = w ? pll_output_clock : pll_reference_clock;
		repeat (300) begin
			@(posedge sys_clk);
			v = w ? pll_output_clock : pll_reference_clock;
			n += int'(v !== p);
			p = v;
		end
	endtask
	initial begin
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		for (i = 0; i < 7; i++) rc(ofs[i], 32'hffffffff, rst[i]);
		wr(8'h0c, $random(seed));
		rc(8'h0c, 32'hffffffff, 32'h00000000);
		$display("test reset and read-only done");
		for (i = 0; i < 2; i++) begin
			if (i == 0) main_on <= 1'b1;
			else slow_on <= 1'b1;
			repeat (40) @(posedge sys_clk);
			flags |= 1 << i;
			rc(8'h04, 32'h3, flags);
			rc(8'h0c, 32'h603, {main_on, 7'h00, slow_on, main_on});
			check(irq, 1'b0);
			wr(8'h10, 1 << i);
			repeat (3) @(posedge sys_clk);
			check(irq, 1'b1);
			wr(8'h08, 32'h00000000);
			rc(8'h04, 32'h3, flags);
			main_on <= 1'b0;
			slow_on <= 1'b0;
			repeat (40) @(posedge sys_clk);
			wr(8'h08, ($random(seed) & ~3) | 3);
			flags = 0;
			rc(8'h04, 32'h3, flags);
			repeat (3) @(posedge sys_clk);
			check(irq, 1'b0);
		end
		$display("test ready flags done");
		for (i = 0; i < 4; i++) begin
			wr(8'h00, 1 | (i << 1));
			tog(0, c);
			check(c != 0, i != 3);
		end
		wr(8'h00, 32'h3);
		tog(0, c);
		wr(8'h00, 32'h303);
		tog(0, d);
		check(d != 0 && d * 3 < c, 1'b1);
		$display("test reference select done");
		wr(8'h18, 32'h2);
		wr(8'h00, 32'hf);
		rdv = 0;
		for (j = 0; j < 100 && rdv[17] !== 1'b1; j++) rd(8'h0c, rdv, rr);
		check(rdv[17], 1'b1);
		check({pll_output_clock, pll_locked_out}, 2'b00);
		wr(8'h00, 32'h0);
		rc(8'h0c, 32'h20000, 32'h0);
		$display("test lock time-out done");
		wr(8'h14, 32'h00020000);
		wr(8'h00, 32'h3);
		for (j = 0; j < 3000 && pll_locked_out !== 1'b1; j++) @(posedge sys_clk);
		check(pll_locked_out, 1'b1);
		tog(1, c);
		check(c != 0, 1'b1);
		rd(8'h40, rdv, rr);
		check({rr, rdv}, 34'h200000000);
		$display("test lock and unmapped done");
		finish_test;
	end
endmodule

// *** hdl/pin_sync.sv ***
// Three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ns
module pin_sync (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic pin_in,
	output logic level,
	output logic rise
);
	logic s1;
	logic s2;
	logic s3;
	logic next_level;
	always_comb begin
		next_level = level;
		if (s2 == s3) begin
			next_level = s3;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			level <= 1'b0;
			rise <= 1'b0;
		end else if (clk_en) begin
			s1 <= pin_in;
			s2 <= s1;
			s3 <= s2;
			level <= next_level;
			rise <= next_level & ~level;
		end
	end
endmodule

// *** hdl/pll_osc_status_ctrl.sv ***
// PLL reference select, fractional PLL control, oscillator flags and status
// How it works
// - Reference picked from slow, main, generic sources
// - Main crystal passes programmable divider first
// - Output gate driven only by PLL control
// - Fractional multiply factor between reference, output
// - Phase compare keeps output aligned to reference
// - Lock timer counts 32kHz lock timer clock ticks
// - Slow crystal flag sets on ready rise
// - Main crystal flag sets on ready rise
// - Write one clears flag, zero ignored
// - Status bit 17 shows lock time-out
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "pll_osc_status_regs.svh"
module pll_osc_status_ctrl
	import pll_osc_status_pkg::*;
#(
	parameter int DIV_WIDTH = 8
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic low_speed_crystal_osc,
	input wire logic main_crystal_osc,
	input wire logic pll_ref_generic_channel,
	input wire logic pll_lock_timer_clock,
	input wire logic slow_xtal_ready,
	input wire logic main_xtal_ready,
	input wire logic brownout_ready,
	input wire logic brownout_detect,
	output logic pll_reference_clock,
	output logic pll_output_clock,
	output logic pll_locked_out,
	output logic irq
);
	initial begin
		if (DIV_WIDTH < 1 || DIV_WIDTH > 16) begin
			$error("DIV_WIDTH out of range");
		end
	end

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Pin-side sampling of reference clocks and ready levels
	logic slow_lvl;
	logic main_lvl;
	logic gen_lvl;
	logic tick_lvl;
	logic slow_rdy_lvl;
	logic main_rdy_lvl;
	logic bo_rdy_lvl;
	logic bo_det_lvl;
	logic main_rise;
	logic gen_rise;
	logic slow_rise;
	logic tick_rise;
	logic slow_rdy_rise;
	logic main_rdy_rise;
	pin_sync u_slow (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
		.pin_in(low_speed_crystal_osc), .level(slow_lvl), .rise(slow_rise));
	pin_sync u_main (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
		.pin_in(main_crystal_osc), .level(main_lvl), .rise(main_rise));
	pin_sync u_gen (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
		.pin_in(pll_ref_generic_channel), .level(gen_lvl), .rise(gen_rise));
	pin_sync u_tick (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
		.pin_in(pll_lock_timer_clock), .level(tick_lvl), .rise(tick_rise));
	pin_sync u_srdy (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
		.pin_in(slow_xtal_ready), .level(slow_rdy_lvl), .rise(slow_rdy_rise));
	pin_sync u_mrdy (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
		.pin_in(main_xtal_ready), .level(main_rdy_lvl), .rise(main_rdy_rise));
	pin_sync u_bor (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
		.pin_in(brownout_ready), .level(bo_rdy_lvl), .rise());
	pin_sync u_bod (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
		.pin_in(brownout_detect), .level(bo_det_lvl), .rise());

	// Software registers
	logic [31:0] ctrl;
	logic [31:0] irq_enable_set;
	logic [31:0] pll_ratio;
	logic [31:0] lock_timeout;
	logic [1:0] ready_flags;
	logic [31:0] next_ctrl;
	logic [31:0] next_irq_enable_set;
	logic [31:0] next_pll_ratio;
	logic [31:0] next_lock_timeout;
	logic [1:0] next_ready_flags;
	logic aw_held;
	logic w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic next_aw_held;
	logic next_w_held;
	logic [7:0] next_aw_addr;
	logic [31:0] next_w_data;
	logic [3:0] next_w_strb;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic do_write;
	logic clear_slow;
	logic clear_main;
	logic [31:0] status_word;

	// Control fields: enable, reference select, divider, lock timer use
	logic pll_enable;
	ref_sel_type ref_sel;
	logic use_lock_timer;
	logic [DIV_WIDTH-1:0] main_div;
	assign pll_enable = ctrl[0];
	assign ref_sel = ref_sel_type'(ctrl[2:1]);
	assign use_lock_timer = ctrl[3];
	assign main_div = ctrl[8 +: DIV_WIDTH];

	// PLL state
	pll_state_type pll_state;
	pll_state_type next_pll_state;
	logic ref_clk;
	logic next_ref_clk;
	logic [DIV_WIDTH-1:0] div_cnt;
	logic [DIV_WIDTH-1:0] next_div_cnt;
	logic div_clk;
	logic next_div_clk;
	logic [31:0] phase_acc;
	logic [31:0] next_phase_acc;
	logic [15:0] out_per_ref;
	logic [15:0] next_out_per_ref;
	logic [15:0] lock_cnt;
	logic [15:0] next_lock_cnt;
	logic lock_fall;
	logic next_lock_fall;
	logic lock_rise_seen;
	logic next_lock_rise_seen;
	logic gate_open;
	logic next_gate_open;
	logic out_clk;
	logic next_out_clk;
	logic ref_edge;
	logic timeout;
	logic next_irq;

	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign clear_slow = do_write && aw_addr == `OFS_IRQ_CLEAR && w_strb[0]
		&& w_data[`BIT_SLOW_XTAL_READY];
	assign clear_main = do_write && aw_addr == `OFS_IRQ_CLEAR && w_strb[0]
		&& w_data[`BIT_MAIN_XTAL_READY];
	assign timeout = pll_state == pll_timed_out;

	always_comb begin
		status_word = 32'h00000000;
		status_word[`BIT_MAIN_XTAL_READY] = main_rdy_lvl;
		status_word[`BIT_SLOW_XTAL_READY] = slow_rdy_lvl;
		status_word[`BIT_BROWNOUT_READY] = bo_rdy_lvl;
		status_word[`BIT_BROWNOUT_DET] = bo_det_lvl;
		status_word[`BIT_PLL_LOCK_RISE] = lock_rise_seen;
		status_word[`BIT_PLL_LOCK_FALL] = lock_fall;
		status_word[`BIT_PLL_LOCK_TIMEOUT] = timeout;
	end

	// Register bus
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = s_axi_bvalid;
		next_bresp = s_axi_bresp;
		next_rvalid = s_axi_rvalid;
		next_rdata = s_axi_rdata;
		next_rresp = s_axi_rresp;
		next_ctrl = ctrl;
		next_irq_enable_set = irq_enable_set;
		next_pll_ratio = pll_ratio;
		next_lock_timeout = lock_timeout;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = 2'b00;
			unique case (aw_addr)
				`OFS_CTRL: next_ctrl = merge_bytes(ctrl, w_data, w_strb);
				`OFS_IRQ_ENABLE: next_irq_enable_set = merge_bytes(irq_enable_set, w_data, w_strb)
					& 32'h00000003;
				`OFS_PLL_RATIO: next_pll_ratio = merge_bytes(pll_ratio, w_data, w_strb);
				`OFS_LOCK_TIMEOUT: next_lock_timeout = merge_bytes(lock_timeout, w_data, w_strb);
				// Status writes dropped on purpose, register is live
				`OFS_IRQ_CLEAR, `OFS_IRQ_STATUS, `OFS_POWER_CLOCK_STATUS: next_bresp = 2'b00;
				default: next_bresp = 2'b10;
			endcase
		end
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp = 2'b00;
			unique case (s_axi_araddr)
				`OFS_CTRL: next_rdata = ctrl;
				`OFS_IRQ_STATUS: next_rdata = {30'h0, ready_flags};
				`OFS_IRQ_CLEAR: next_rdata = 32'h00000000;
				`OFS_POWER_CLOCK_STATUS: next_rdata = status_word;
				`OFS_IRQ_ENABLE: next_rdata = irq_enable_set;
				`OFS_PLL_RATIO: next_rdata = pll_ratio;
				`OFS_LOCK_TIMEOUT: next_rdata = lock_timeout;
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = 2'b10;
				end
			endcase
		end
	end

	// Ready flags: hardware set wins over a clear in the same cycle
	always_comb begin
		next_ready_flags = ready_flags;
		if (clear_slow) begin
			next_ready_flags[`BIT_SLOW_XTAL_READY] = 1'b0;
		end
		if (clear_main) begin
			next_ready_flags[`BIT_MAIN_XTAL_READY] = 1'b0;
		end
		if (slow_rdy_rise) begin
			next_ready_flags[`BIT_SLOW_XTAL_READY] = 1'b1;
		end
		if (main_rdy_rise) begin
			next_ready_flags[`BIT_MAIN_XTAL_READY] = 1'b1;
		end
		next_irq = |(next_ready_flags & irq_enable_set[1:0]);
	end

	// Reference path and PLL core
	always_comb begin
		next_div_cnt = div_cnt;
		next_div_clk = div_clk;
		if (main_rise) begin
			if (div_cnt >= main_div) begin
				next_div_cnt = '0;
				next_div_clk = ~div_clk;
			end else begin
				next_div_cnt = div_cnt + 1'b1;
			end
		end
		unique case (ref_sel)
			ref_slow_xtal: next_ref_clk = slow_lvl;
			ref_main_xtal: next_ref_clk = div_clk;
			ref_generic: next_ref_clk = gen_lvl;
			default: next_ref_clk = 1'b0;
		endcase
	end
	assign ref_edge = next_ref_clk & ~ref_clk;

	always_comb begin
		next_pll_state = pll_state;
		next_phase_acc = phase_acc;
		next_out_per_ref = out_per_ref;
		next_lock_cnt = lock_cnt;
		next_lock_fall = lock_fall;
		next_lock_rise_seen = lock_rise_seen;
		next_out_clk = out_clk;
		next_gate_open = 1'b0;
		// Fractional ratio: integer in [31:16], fraction in [15:0]
		next_phase_acc = phase_acc + pll_ratio;
		if (phase_acc[31:16] != next_phase_acc[31:16] && gate_open) begin
			next_out_clk = ~out_clk;
		end
		// Count output steps ungated, lock needs them before the gate opens
		if (phase_acc[31:16] != next_phase_acc[31:16]) begin
			next_out_per_ref = out_per_ref + 16'h0001;
		end
		if (!pll_enable) begin
			next_pll_state = pll_off;
			next_phase_acc = 32'h00000000;
			next_out_clk = 1'b0;
			next_lock_cnt = 16'h0000;
			next_lock_rise_seen = 1'b0;
		end else begin
			unique case (pll_state)
				pll_off: begin
					next_pll_state = pll_locking;
					next_lock_cnt = 16'h0000;
				end
				pll_locking: begin
					if (ref_edge) begin
						// Phase compare: realign output to the reference edge
						next_phase_acc = 32'h00000000;
						next_out_per_ref = 16'h0000;
						if (out_per_ref != 16'h0000) begin
							next_pll_state = pll_locked;
							next_lock_rise_seen = 1'b1;
						end
					end else if (use_lock_timer && tick_rise) begin
						next_lock_cnt = lock_cnt + 16'h0001;
						if (lock_cnt + 16'h0001 >= lock_timeout[15:0]) begin
							next_pll_state = pll_timed_out;
						end
					end
				end
				pll_locked: begin
					next_gate_open = 1'b1;
					if (ref_edge) begin
						next_phase_acc = 32'h00000000;
						next_out_per_ref = 16'h0000;
					end
					if (ref_sel == ref_unused) begin
						next_pll_state = pll_locking;
						next_lock_fall = 1'b1;
						next_lock_cnt = 16'h0000;
					end
				end
				pll_timed_out: next_pll_state = pll_timed_out;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_arready <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
			ctrl <= `CTRL_RESET;
			irq_enable_set <= 32'h00000000;
			pll_ratio <= `PLL_RATIO_RESET;
			lock_timeout <= `LOCK_TIMEOUT_RESET;
			ready_flags <= 2'b00;
			irq <= 1'b0;
			pll_state <= pll_off;
			ref_clk <= 1'b0;
			div_cnt <= '0;
			div_clk <= 1'b0;
			phase_acc <= 32'h00000000;
			out_per_ref <= 16'h0000;
			lock_cnt <= 16'h0000;
			lock_fall <= 1'b0;
			lock_rise_seen <= 1'b0;
			gate_open <= 1'b0;
			out_clk <= 1'b0;
			pll_reference_clock <= 1'b0;
			pll_output_clock <= 1'b0;
			pll_locked_out <= 1'b0;
		end else if (clk_en) begin
			s_axi_awready <= !next_aw_held && !next_bvalid;
			s_axi_wready <= !next_w_held && !next_bvalid;
			s_axi_arready <= !next_rvalid;
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			s_axi_bvalid <= next_bvalid;
			s_axi_bresp <= next_bresp;
			s_axi_rvalid <= next_rvalid;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
			ctrl <= next_ctrl;
			irq_enable_set <= next_irq_enable_set;
			pll_ratio <= next_pll_ratio;
			lock_timeout <= next_lock_timeout;
			ready_flags <= next_ready_flags;
			irq <= next_irq;
			pll_state <= next_pll_state;
			ref_clk <= next_ref_clk;
			div_cnt <= next_div_cnt;
			div_clk <= next_div_clk;
			phase_acc <= next_phase_acc;
			out_per_ref <= next_out_per_ref;
			lock_cnt <= next_lock_cnt;
			lock_fall <= next_lock_fall;
			lock_rise_seen <= next_lock_rise_seen;
			gate_open <= next_gate_open;
			out_clk <= next_out_clk;
			pll_reference_clock <= next_ref_clk;
			pll_output_clock <= next_out_clk & next_gate_open;
			pll_locked_out <= next_pll_state == pll_locked;
		end
	end
endmodule

// *** hdl/pll_osc_status_pkg.sv ***
// Types shared by the clock controller slice
package pll_osc_status_pkg;
	typedef enum logic [1:0] {
		ref_slow_xtal = 2'b00,
		ref_main_xtal = 2'b01,
		ref_generic = 2'b10,
		ref_unused = 2'b11
	} ref_sel_type;
	typedef enum logic [1:0] {
		pll_off = 2'b00,
		pll_locking = 2'b01,
		pll_locked = 2'b10,
		pll_timed_out = 2'b11
	} pll_state_type;
endpackage

// *** hdl/pll_osc_status_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef PLL_OSC_STATUS_REGS_SVH
`define PLL_OSC_STATUS_REGS_SVH
`define OFS_CTRL 8'h00
`define OFS_IRQ_STATUS 8'h04
`define OFS_IRQ_CLEAR 8'h08
`define OFS_POWER_CLOCK_STATUS 8'h0c
`define OFS_IRQ_ENABLE 8'h10
`define OFS_PLL_RATIO 8'h14
`define OFS_LOCK_TIMEOUT 8'h18
`define BIT_MAIN_XTAL_READY 0
`define BIT_SLOW_XTAL_READY 1
`define BIT_BROWNOUT_READY 9
`define BIT_BROWNOUT_DET 10
`define BIT_PLL_LOCK_RISE 15
`define BIT_PLL_LOCK_FALL 16
`define BIT_PLL_LOCK_TIMEOUT 17
`define CTRL_RESET 32'h00000000
`define PLL_RATIO_RESET 32'h00010000
`define LOCK_TIMEOUT_RESET 32'h00000040
`define SYNC_STAGES 3
`endif
